// ### shp_regs.vh
// shared prescaler constants: option field positions, reset values
// assumes inclusion by the prescaler design files only
`ifndef SHP_REGS_VH
`define SHP_REGS_VH
`define SHP_OPT_PS_LSB    0
`define SHP_OPT_PS_MSB    2
`define SHP_OPT_PSA_BIT   3
`define SHP_OPT_RESET     8'hFF
`define SHP_CNT_RESET     8'h00
`define SHP_CNT_WIDTH     8
`endif

// ### shp_ratio_tap.v
// shared prescaler ratio tap: picks the counter bit that forms the divided output
// assumes a free-running count and a 3-bit ratio field from the same clock domain
`include "shp_regs.vh"
module shp_ratio_tap #(
  parameter WIDTH = `SHP_CNT_WIDTH
) (
  // count and ratio
  input  wire [WIDTH-1:0] count,
  input  wire [2:0]       ratio,
  input  wire             assign_wdt,
  // tapped bit
  output reg              tap
);
  // timer divides by 2^(ps+1), watchdog by 2^ps
  always @* begin
    if (assign_wdt) begin
      if (ratio == 3'h0)
        tap = 1'b0;
      else
        tap = count[ratio - 3'h1];
    end else begin
      tap = count[ratio];
    end
  end
endmodule

// ### shp_prescaler.v
// shared prescaler: one 8-bit divide counter for the timer or the watchdog
// assumes core-side strobes are synchronous to clock; pin-side tick is synchronised here
//
// Functional notes
// (R1) one 8-bit divide counter, timer prescaler or watchdog postscaler
// (R2) counter serves one user; the other user runs undivided
// (R3) assign bit and 3-bit ratio come from option register low bits
// (R4) timer assigned: any timer count write clears the counter
// (R5) watchdog assigned: watchdog clear clears counter and watchdog
// (R6) no software read or direct write of the counter value
// (R7) counter is zero after any reset
// (R8) assignment changes take effect on option write, no halt needed
// (R9) software order for timer to watchdog switch avoids spurious reset
// (R10) software clears watchdog before switching to timer
// (R11) output pulses once every 2^(ps+1) timer ticks, 2^ps watchdog ticks
`include "shp_regs.vh"
module shp_prescaler #(
  parameter WIDTH = `SHP_CNT_WIDTH
) (
  // clock and reset
  input  wire       clock,
  input  wire       rst,
  // core side
  input  wire       option_wr,
  input  wire [7:0] option_data,
  input  wire       timer_count_wr,
  input  wire       wdt_clear,
  input  wire       timer_tick,
  // watchdog oscillator tick, asynchronous
  input  wire       wdt_tick_async,
  // outputs
  output reg        timer_inc_q,
  output reg        wdt_inc_q,
  output reg        wdt_clear_q,
  output reg        assign_wdt_q,
  output reg  [2:0] ratio_q
);
  // reset images of the option fields and the counter
  localparam [7:0]       OPT_RESET = `SHP_OPT_RESET;
  localparam [WIDTH-1:0] CNT_RESET = `SHP_CNT_RESET;
  localparam [WIDTH-1:0] CNT_ONE   = {{(WIDTH-1){1'b0}}, 1'b1};

  // divide counter and the bit tapped from it
  reg  [WIDTH-1:0] count_q;
  reg  [WIDTH-1:0] count_d;
  reg              tap_q;
  reg              tap_d;
  wire             tap;
  reg              div_edge;

  // watchdog oscillator synchroniser and edge detect
  reg              sync1_q;
  reg              sync2_q;
  reg              sync3_q;
  wire             wdt_tick;

  // option fields, next values
  reg              assign_wdt_d;
  reg        [2:0] ratio_d;

  // counter source and clear for the current user
  reg              src_tick;
  reg              clr;

  // registered outputs, next values
  reg              timer_inc_d;
  reg              wdt_inc_d;
  reg              wdt_clear_d;

  // first stage, reads the pin
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      sync1_q <= 1'b0;
    end else begin
      sync1_q <= wdt_tick_async;
    end
  end

  // second stage, the only reader of the first
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      sync2_q <= 1'b0;
    end else begin
      sync2_q <= sync1_q;
    end
  end

  // edge detect stage, idle low like the pin
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      sync3_q <= 1'b0;
    end else begin
      sync3_q <= sync2_q;
    end
  end

  // one tick per rising edge of the oscillator
  assign wdt_tick = sync2_q & ~sync3_q;

  // option fields taken on the option write
  always @* begin
    assign_wdt_d = assign_wdt_q;
    ratio_d      = ratio_q;
    if (option_wr) begin
      assign_wdt_d = option_data[`SHP_OPT_PSA_BIT]; // R3 R8
      ratio_d      = option_data[`SHP_OPT_PS_MSB:`SHP_OPT_PS_LSB]; // R3
    end
  end

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      assign_wdt_q <= OPT_RESET[`SHP_OPT_PSA_BIT];
    end else begin
      assign_wdt_q <= assign_wdt_d;
    end
  end

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      ratio_q <= OPT_RESET[`SHP_OPT_PS_MSB:`SHP_OPT_PS_LSB];
    end else begin
      ratio_q <= ratio_d;
    end
  end

  // clearing side effects are the only writes to the counter (R6)
  always @* begin
    clr      = timer_count_wr; // R4
    src_tick = timer_tick; // R2
    if (assign_wdt_q) begin
      clr      = wdt_clear; // R5
      src_tick = wdt_tick; // R2
    end
  end

  // clear beats a tick in the same cycle
  always @* begin
    count_d = count_q;
    if (clr) begin
      count_d = CNT_RESET;
    end else if (src_tick) begin
      count_d = count_q + CNT_ONE; // R1
    end
  end

  // counter register, zero after any reset
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      count_q <= CNT_RESET; // R7
    end else begin
      count_q <= count_d;
    end
  end

  shp_ratio_tap #(.WIDTH(WIDTH)) u_tap (
    .count      (count_q),
    .ratio      (ratio_q),
    .assign_wdt (assign_wdt_q),
    .tap        (tap)
  );

  // clear forgets the tap and drops its edge, so no divided pulse comes in the clear cycle
  always @* begin
    tap_d    = tap;
    div_edge = tap & ~tap_q & ~clr;
    if (clr) begin
      tap_d = 1'b0;
    end
  end

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      tap_q <= 1'b0;
    end else begin
      tap_q <= tap_d;
    end
  end

  // the unassigned user runs undivided
  always @* begin
    timer_inc_d = timer_tick; // R2
    wdt_inc_d   = wdt_tick; // R2
    wdt_clear_d = wdt_clear; // R5
    if (assign_wdt_q) begin
      // watchdog ratio 0: every tick passes except one in a clear cycle
      if (ratio_q == 3'h0) begin
        wdt_inc_d = wdt_tick & ~clr; // R11
      end else begin
        wdt_inc_d = div_edge; // R11
      end
    end else begin
      timer_inc_d = div_edge; // R11
    end
  end

  // every output comes straight from a flop
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      timer_inc_q <= 1'b0;
    end else begin
      timer_inc_q <= timer_inc_d;
    end
  end

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      wdt_inc_q <= 1'b0;
    end else begin
      wdt_inc_q <= wdt_inc_d;
    end
  end

  // watchdog clear follows the instruction one cycle later
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      wdt_clear_q <= 1'b0;
    end else begin
      wdt_clear_q <= wdt_clear_d;
    end
  end
endmodule

// ### shp_prescaler_properties.sv
// port assertions for the shared prescaler
// assumes a bind onto shp_prescaler
module shp_prescaler_properties (
  // clock and reset
  input wire logic       clock,
  input wire logic       rst,
  // core side strobes
  input wire logic       option_wr,
  input wire logic [7:0] option_data,
  input wire logic       wdt_clear,
  input wire logic       timer_tick,
  // registered outputs
  input wire logic       timer_inc_q,
  input wire logic       wdt_clear_q,
  input wire logic       assign_wdt_q,
  input wire logic [2:0] ratio_q
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  sequence s_clr; wdt_clear ##1 wdt_clear_q; endsequence
  chk_opt_ratio: assert property (option_wr |=> ratio_q == $past(option_data[2:0]))
    else $error("ratio");
  chk_opt_assign: assert property (option_wr |=> assign_wdt_q == $past(option_data[3]))
    else $error("assign");
  chk_opt_hold: assert property (!option_wr |=> $stable({assign_wdt_q, ratio_q}))
    else $error("hold");
  chk_clr_copy: assert property (wdt_clear |-> s_clr)
    else $error("clear");
  chk_clr_only: assert property (!wdt_clear |=> !wdt_clear_q)
    else $error("no clear");
  chk_tmr_pass: assert property (assign_wdt_q && timer_tick && !option_wr |=> timer_inc_q)
    else $error("pass");
  chk_tmr_div: assert property (!assign_wdt_q && timer_inc_q |=> !timer_inc_q)
    else $error("div");
  chk_rst_vals: assert property ($fell(rst) |-> assign_wdt_q && ratio_q == 3'h7)
    else $error("reset");
endmodule
bind shp_prescaler shp_prescaler_properties chk (
  .clock        (clock),
  .rst          (rst),
  .option_wr    (option_wr),
  .option_data  (option_data),
  .wdt_clear    (wdt_clear),
  .timer_tick   (timer_tick),
  .timer_inc_q  (timer_inc_q),
  .wdt_clear_q  (wdt_clear_q),
  .assign_wdt_q (assign_wdt_q),
  .ratio_q      (ratio_q)
);

// ### shared_prescaler_bench.sv
// self-checking bench for the shared prescaler
// assumes shp_prescaler with its bound checker
module shared_prescaler_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 0, rst = 1, option_wr = 0, timer_count_wr = 0, wdt_clear = 0, timer_tick = 0;
  logic wdt_tick_async = 0, timer_inc_q, wdt_inc_q, wdt_clear_q, assign_wdt_q;
  logic [7:0] option_data = 8'h00;
  logic [2:0] ratio_q;
  int err_count = 0, checked = 0, pulses = 0, p0 = 0, cycles = 0;
  int wpulses = 0, w0 = 0;
  // option byte, timer pulses over 300 ticks, watchdog pulses over 40 ticks
  logic [27:0] rows [13] = '{28'h0812C28, 28'h0F12C00, 28'h0009628, 28'h0104B28,
    28'h0202628, 28'h0301328, 28'h0400928, 28'h0500528, 28'h0600228, 28'h0700128,
    28'h0912C14, 28'h0B12C05, 28'h0D12C01};
  shp_prescaler dut (
    .clock          (clock),
    .rst            (rst),
    .option_wr      (option_wr),
    .option_data    (option_data),
    .timer_count_wr (timer_count_wr),
    .wdt_clear      (wdt_clear),
    .timer_tick     (timer_tick),
    .wdt_tick_async (wdt_tick_async),
    .timer_inc_q    (timer_inc_q),
    .wdt_inc_q      (wdt_inc_q),
    .wdt_clear_q    (wdt_clear_q),
    .assign_wdt_q   (assign_wdt_q),
    .ratio_q        (ratio_q)
  );
  initial forever #5 clock = ~clock;
  always @(posedge clock) begin
    if (!rst) begin
      pulses  <= pulses + timer_inc_q;
      wpulses <= wpulses + wdt_inc_q;
    end
    cycles <= cycles + 1;
    if (cycles == 12000) begin
      err_count++;
      test_done();
    end
  end
  task test_done;
    if (err_count == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task chk(input string nm, input logic [11:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s exp %0d seen %0d", nm, exp, seen);
    end
  endtask
  task op(input logic [7:0] d);
    @(negedge clock) option_wr = 1;
    option_data = d;
    @(negedge clock) option_wr = 0;
  endtask
  task clr(input logic t);
    @(negedge clock) {timer_count_wr, wdt_clear} = {t, !t};
    @(negedge clock) {timer_count_wr, wdt_clear} = 2'b00;
  endtask
  task tick(input int n);
    repeat (n) @(negedge clock) timer_tick = 1;
    @(negedge clock) timer_tick = 0;
    repeat (3) @(negedge clock);
  endtask
  // oscillator ticks: two cycles high, two low, then time for the pipeline
  task wtick(input int n);
    repeat (n) begin
      @(negedge clock) wdt_tick_async = 1;
      @(negedge clock);
      @(negedge clock) wdt_tick_async = 0;
      @(negedge clock);
    end
    repeat (6) @(negedge clock);
  endtask
  initial begin
    repeat (6) @(negedge clock);
    rst = 0;
    chk("reset", {assign_wdt_q, ratio_q}, 12'hF);
    foreach (rows[i]) begin
      op(rows[i][27:20]);
      clr(!rows[i][23]);
      p0 = pulses;
      w0 = wpulses;
      tick(300);
      wtick(40);
      chk("timer pulses", pulses - p0, rows[i][19:8]);
      chk("wdt pulses", wpulses - w0, rows[i][7:0]);
    end
    clr(0);
    op(8'h01);
    clr(1);
    p0 = pulses;
    tick(2);
    clr(1);
    tick(2);
    chk("tmr clear", pulses - p0, 12'h2);
    clr(1);
    p0 = pulses;
    tick(2);
    clr(0);
    tick(2);
    chk("wdt clear", pulses - p0, 12'h1);
    clr(0);
    clr(1);
    op(8'h0F);
    clr(0);
    op(8'h09);
    w0 = wpulses;
    wtick(1);
    clr(0);
    wtick(1);
    clr(1);
    wtick(1);
    chk("wdt divide clear", wpulses - w0, 12'h2);
    rst = 1;
    @(negedge clock) rst = 0;
    chk("reset", {assign_wdt_q, ratio_q}, 12'hF);
    op(8'h01);
    p0 = pulses;
    tick(2);
    chk("counter reset", pulses - p0, 12'h1);
    test_done();
  end
endmodule
